/* core/fbs_pkg.sv */
// Shared constants and types for the flow-through burst SRAM access block
package fbs_pkg;
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = 9;
  localparam int WORD_W = 36;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int BURST_LEN = 4;
  localparam int LO_W = 2;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] LO_RST = 2'h0;
  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [1:0] SYNC_OE_RST = 2'h3;
  localparam logic [1:0] SYNC_ORDER_RST = 2'h0;
  localparam logic ORDER_LINEAR = 1'h0;
  localparam logic ORDER_INTERLEAVED = 1'h1;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } fbs_op_e;
endpackage

/* core/fbs_sram_access.sv */
// Flow-through burst SRAM access logic with posted-write FIFO and array
// Contract
// R1: All synchronous inputs are captured only on the rising clock edge.
// R2: Clock qualifier high makes the edge ignored; all state holds. The code still shifts the drive enable and strap synchronisers on such edges.
// R3: Qualified load with all selects active and write strobe high starts a read.
// R4: After the read edge, data and parity drive only while output drive enable low; the code sees that enable two edges late via a synchroniser.
// R5: A new read, write or deselect is accepted on the edge after a read.
// R6: Load with any select inactive deselects and releases outputs at once.
// R7: Burst counter lets one address serve up to four accesses.
// R8: Burst order linear with strap low, interleaved with strap high.
// R9: Burst counter changes only the two low address bits, wrapping in four.
// R10: Advance high steps the counter and ignores selects and write strobe.
// R11: Direction is latched at burst load and kept through the burst.
// R12: Qualified load, selects active, write strobe low starts a write, latches lanes.
// R13: Data and parity drivers stay off during a write data cycle.
// R14: Write data is taken one qualified edge after the command; new op same edge.
// R15: Only byte lanes with active select are written; others stay unchanged.
// R16: Host keeps off the data lines while the device drives them.
// R17: Host loads a fresh address after a deselect.
// R18: Selects one and three active low, two active high, all needed.
// R19: Outputs stay off while deselected and in the first clock after leaving.
// R20: Linear adds count modulo four; interleaved XORs start with count.
// R21: Each lane select gates its byte and its parity bit, nine bits a lane.
`timescale 1ns/1ns

module fbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data = store[rd_ptr_reg];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule // fbs_fifo

module fbs_sram_access #(
  parameter int ADDR_W = fbs_pkg::ADDR_W,
  parameter int FIFO_DEPTH = fbs_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_qualify_n,
  input wire logic select_low_first_n,
  input wire logic select_high_second,
  input wire logic select_low_third_n,
  input wire logic advance_not_load,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [fbs_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic output_drive_n,
  input wire logic burst_order,
  input wire logic [fbs_pkg::DATA_W-1:0] data_in,
  output logic [fbs_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [fbs_pkg::LANES-1:0] lane_parity_lines_in,
  output logic [fbs_pkg::LANES-1:0] lane_parity_lines_out,
  output logic lane_parity_lines_oe,
  output logic write_buffer_ready
);
  localparam int FW = ADDR_W + fbs_pkg::WORD_W + fbs_pkg::LANES;
  localparam int HI_W = ADDR_W - fbs_pkg::LO_W;

  // Low two address bits for burst position cnt from start base
  function automatic logic [1:0] fbs_burst_lo(input logic [1:0] base, input logic [1:0] cnt,
                                              input logic order);
    fbs_burst_lo = (order == fbs_pkg::ORDER_INTERLEAVED) ? (base ^ cnt) : 2'(base + cnt); // [R8] [R9] [R20]
  endfunction

  logic [fbs_pkg::WORD_W-1:0] mem [2**ADDR_W];
  fbs_pkg::fbs_op_e op_reg, op_next;
  logic [HI_W-1:0] addr_hi_reg;
  logic [1:0] base_lo_reg;
  logic [1:0] cnt_reg;
  logic rd_live_reg;
  logic wr_pend_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [fbs_pkg::LANES-1:0] wmask_reg;
  logic [fbs_pkg::WORD_W-1:0] rdata_reg;
  logic [1:0] oe_sync_reg;
  logic [1:0] order_sync_reg;

  // Selection and command decode; every command is qualified by the clock qualifier
  wire sel_all = !select_low_first_n && select_high_second && !select_low_third_n; // [R18]
  wire edge_ok = !clock_qualify_n; // [R2]
  wire load_req = edge_ok && !advance_not_load;
  wire start_rd = load_req && sel_all && write_strobe_n; // [R3]
  wire start_wr = load_req && sel_all && !write_strobe_n; // [R12]
  wire desel = load_req && !sel_all; // [R6]
  wire step = edge_ok && advance_not_load && (op_reg != fbs_pkg::OP_IDLE); // [R10] [R7]
  wire order = order_sync_reg[1];
  wire [1:0] cnt_step = 2'(cnt_reg + 2'h1);
  wire [1:0] step_lo = fbs_burst_lo(base_lo_reg, cnt_step, order); // [R9]
  wire [ADDR_W-1:0] acc_addr = (start_rd || start_wr) ? addr : {addr_hi_reg, step_lo};
  wire rd_access = start_rd || (step && op_reg == fbs_pkg::OP_READ);
  wire wr_access = start_wr || (step && op_reg == fbs_pkg::OP_WRITE);

  // Write data word: each lane is {parity, byte}, lane A in the lowest nine bits
  logic [fbs_pkg::WORD_W-1:0] wdata_word;
  always_comb begin
    for (int i = 0; i < fbs_pkg::LANES; i++) begin
      wdata_word[i*fbs_pkg::LANE_W +: fbs_pkg::LANE_W] =
        {lane_parity_lines_in[i], data_in[i*fbs_pkg::BYTE_W +: fbs_pkg::BYTE_W]}; // [R21]
    end
  end

  // Posted writes; the array port is shared and reads win, so a long read
  // burst backs the buffer up. A read of a still-buffered address sees old data.
  // Every write access edge also drains, so legal host traffic keeps it nearly empty.
  wire push_valid = edge_ok && wr_pend_reg && (wmask_reg != fbs_pkg::MASK_RST); // [R14]
  wire drain_ok = edge_ok && !rd_access;
  wire drain_valid;
  wire [FW-1:0] drain_word;
  wire [ADDR_W-1:0] drain_addr = drain_word[FW-1 -: ADDR_W];
  wire [fbs_pkg::WORD_W-1:0] drain_data = drain_word[fbs_pkg::LANES +: fbs_pkg::WORD_W];
  wire [fbs_pkg::LANES-1:0] drain_mask = drain_word[fbs_pkg::LANES-1:0];

  fbs_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(write_buffer_ready),
    .in_data({waddr_reg, wdata_word, wmask_reg}),
    .out_valid(drain_valid),
    .out_ready(drain_ok),
    .out_data(drain_word)
  );

  always_comb begin
    op_next = op_reg;
    case (op_reg)
      fbs_pkg::OP_IDLE, fbs_pkg::OP_READ, fbs_pkg::OP_WRITE: begin
        if (desel) begin
          op_next = fbs_pkg::OP_IDLE;
        end else if (start_rd) begin
          op_next = fbs_pkg::OP_READ; // [R5]
        end else if (start_wr) begin
          op_next = fbs_pkg::OP_WRITE;
        end
      end
      default: op_next = fbs_pkg::OP_IDLE;
    endcase
  end

  // Array: read at the access edge so data is valid the cycle after it
  always_ff @(posedge sys_clk) begin
    if (rd_access) begin
      rdata_reg <= mem[acc_addr];
    end
    if (drain_valid && drain_ok) begin
      for (int i = 0; i < fbs_pkg::LANES; i++) begin
        if (!drain_mask[i]) begin
          mem[drain_addr][i*fbs_pkg::LANE_W +: fbs_pkg::LANE_W] <=
            drain_data[i*fbs_pkg::LANE_W +: fbs_pkg::LANE_W]; // [R15] [R21]
        end
      end
    end
  end

  // Pin-level asynchronous inputs pass two flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      oe_sync_reg <= fbs_pkg::SYNC_OE_RST;
      order_sync_reg <= fbs_pkg::SYNC_ORDER_RST;
    end else begin
      oe_sync_reg <= {oe_sync_reg[0], output_drive_n};
      order_sync_reg <= {order_sync_reg[0], burst_order};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_reg <= fbs_pkg::OP_IDLE;
      addr_hi_reg <= '0;
      base_lo_reg <= fbs_pkg::LO_RST;
      cnt_reg <= fbs_pkg::CNT_RST;
      rd_live_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      waddr_reg <= '0;
      wmask_reg <= fbs_pkg::MASK_RST;
    end else if (edge_ok) begin // [R1] [R2]
      op_reg <= op_next; // [R11]
      if (start_rd || start_wr) begin
        addr_hi_reg <= addr[ADDR_W-1:fbs_pkg::LO_W];
        base_lo_reg <= addr[fbs_pkg::LO_W-1:0];
        cnt_reg <= fbs_pkg::CNT_RST;
      end else if (step) begin
        cnt_reg <= cnt_step; // [R7] [R9]
      end
      rd_live_reg <= rd_access; // [R6] [R19]
      wr_pend_reg <= wr_access; // [R14]
      if (wr_access) begin
        waddr_reg <= acc_addr;
        wmask_reg <= byte_lane_write_n; // [R12] [R15]
      end
    end
  end

  assign data_oe = rd_live_reg && !oe_sync_reg[1]; // [R4] [R13] [R19]
  assign lane_parity_lines_oe = data_oe;
  always_comb begin
    for (int i = 0; i < fbs_pkg::LANES; i++) begin
      data_out[i*fbs_pkg::BYTE_W +: fbs_pkg::BYTE_W] = rdata_reg[i*fbs_pkg::LANE_W +: fbs_pkg::BYTE_W];
      lane_parity_lines_out[i] = rdata_reg[i*fbs_pkg::LANE_W + fbs_pkg::BYTE_W];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  qualify_hold_a: assert property (clock_qualify_n |=> $stable(op_reg) && $stable(cnt_reg) // [R2]
    && $stable(rd_live_reg) && $stable(wr_pend_reg) && $stable(addr_hi_reg))
    else $error("state moved on an ignored edge");
  read_drive_a: assert property (start_rd ##1 !oe_sync_reg[1] // [R4]
    |-> data_oe && lane_parity_lines_oe)
    else $error("read data not driven after read edge");
  write_quiet_a: assert property (wr_pend_reg |-> !data_oe) // [R13]
    else $error("drivers on during write data cycle");
  deselect_off_a: assert property (desel |=> !data_oe && op_reg == fbs_pkg::OP_IDLE) // [R6]
    else $error("outputs not released on deselect");
  burst_step_a: assert property (step |=> addr_hi_reg == $past(addr_hi_reg) // [R9]
    && cnt_reg == 2'($past(cnt_reg) + 2'h1))
    else $error("burst step touched wrong bits");
  burst_order_a: assert property (start_rd && !advance_not_load ##1 step && order // [R20]
    |-> acc_addr[1:0] == (base_lo_reg ^ 2'h1))
    else $error("interleaved second address wrong");
  dir_keep_a: assert property (step |=> op_reg == $past(op_reg)) // [R11]
    else $error("burst direction changed");
  read_next_a: assert property (start_rd ##1 start_wr |=> op_reg == fbs_pkg::OP_WRITE // [R5]
    && !rd_live_reg)
    else $error("write after read not accepted");
  write_mask_a: assert property (start_wr |=> wr_pend_reg // [R12]
    && wmask_reg == $past(byte_lane_write_n))
    else $error("write lanes not latched");
  write_push_a: assert property (wr_pend_reg && edge_ok && wmask_reg != fbs_pkg::MASK_RST // [R14]
    |=> drain_valid)
    else $error("write data not taken on next edge");
  // A stall must freeze the datapath registers as well as the control state
  stall_data_a: assert property (clock_qualify_n |=> $stable(rdata_reg) && $stable(wmask_reg) // [R2]
    && $stable(waddr_reg) && $stable(base_lo_reg))
    else $error("datapath moved on an ignored edge");
  oe_gate_a: assert property (oe_sync_reg[1] |-> !data_oe && !lane_parity_lines_oe) // [R4]
    else $error("drivers on with output drive enable high");
  linear_next_a: assert property (start_rd && !order ##1 step && !order // [R8]
    |-> acc_addr[1:0] == 2'($past(addr[1:0]) + 2'h1))
    else $error("linear second address wrong");
  idle_step_a: assert property (edge_ok && advance_not_load && op_reg == fbs_pkg::OP_IDLE // [R6]
    |=> !rd_live_reg && !wr_pend_reg && op_reg == fbs_pkg::OP_IDLE)
    else $error("step after deselect started an access");
  write_off_a: assert property (wr_access |=> !data_oe && !lane_parity_lines_oe) // [R13]
    else $error("drivers on after write access");
  leave_desel_a: assert property (desel ##1 start_rd |-> !data_oe) // [R19]
    else $error("drivers on in first clock after deselect");
  burst_wrap_a: assert property (step && cnt_reg == 2'h3 |=> cnt_reg == 2'h0 && $stable(addr_hi_reg)) // [R9]
    else $error("burst counter did not wrap in group");

  burst_read_c: cover property (start_rd ##1 step [*3]);
  write_read_c: cover property (start_wr ##1 start_rd ##1 data_oe);
  stall_c: cover property (wr_pend_reg && clock_qualify_n ##1 push_valid);
  buffer_full_c: cover property (!write_buffer_ready);
  deselect_c: cover property (start_rd ##1 desel ##1 !data_oe);
endmodule // fbs_sram_access

/* tb/fbs_host_model.sv */
// Host-side memory controller model that drives the SRAM access block
`timescale 1ns/1ns
module fbs_host_model (
  input wire logic sys_clk,
  output logic clock_qualify_n,
  output logic select_low_first_n,
  output logic select_high_second,
  output logic select_low_third_n,
  output logic advance_not_load,
  output logic write_strobe_n,
  output logic [fbs_pkg::ADDR_W-1:0] addr,
  output logic [fbs_pkg::LANES-1:0] byte_lane_write_n,
  output logic output_drive_n,
  output logic burst_order,
  output logic [fbs_pkg::DATA_W-1:0] data_in,
  output logic [fbs_pkg::LANES-1:0] lane_parity_lines_in
);
  logic [35:0] mem [int];
  logic [36:0] notes [$];
  logic [36:0] last = '0;
  logic [16:0] base = '0;
  logic [16:0] pa = '0;
  logic [1:0] cnt = '0;
  logic [1:0] lo;
  logic [3:0] pbw;
  logic live = 0;
  logic rd = 0;
  logic pend = 0;
  int seed = 47361;
  initial begin
    {clock_qualify_n, advance_not_load, output_drive_n, burst_order, addr} = '0;
    {select_low_first_n, select_high_second, select_low_third_n, write_strobe_n} = 4'h9;
    {byte_lane_write_n, data_in, lane_parity_lines_in} = '1;
  end
  // One edge of traffic; the note is {expect drive, {parity, data}}
  task automatic tick(input logic cq, input logic [2:0] sel, input logic adv, input logic we,
                      input logic [16:0] a, input logic [3:0] bw);
    clock_qualify_n = cq;
    {select_low_first_n, select_high_second, select_low_third_n} = sel;
    advance_not_load = adv;
    write_strobe_n = we;
    addr = a;
    byte_lane_write_n = bw;
    data_in = $random(seed);
    lane_parity_lines_in = 4'($random(seed));
    @(posedge sys_clk);
    if (!cq) begin
      if (pend) for (int i = 0; i < 4; i++) if (!pbw[i]) begin
        mem[pa][8*i+:8] = data_in[8*i+:8];
        mem[pa][32+i] = lane_parity_lines_in[i];
      end
      pend = 0;
      if (!adv) begin
        live = (sel == 3'b010);
        base = a;
        cnt = '0;
        rd = we;
      end else cnt++;
      lo = burst_order ? base[1:0] ^ cnt : base[1:0] + cnt;
      last = '0;
      if (live && rd) last = {!output_drive_n, mem[{base[16:2], lo}]};
      else if (live) {pend, pa, pbw} = {1'b1, base[16:2], lo, bw};
    end
    notes.push_back(last);
    #1;
  endtask
  task automatic ld(input logic we, input logic [16:0] a, input logic [3:0] bw);
    tick(0, 3'b010, 0, we, a, bw);
  endtask
  // Steps drive selects inactive and the opposite strobe so that both must be ignored
  task automatic step(input logic [3:0] bw);
    tick(0, 3'b101, 1, !rd, 17'($random(seed)), bw);
  endtask
  task automatic idle(input int n);
    repeat (n) tick(0, 3'b110, 0, 1, '0, 4'hf);
  endtask
  // Strap and drive enable move only between accesses, behind three idle edges
  task automatic cfg(input logic o, input logic oe);
    burst_order = o;
    output_drive_n = oe;
    idle(3);
  endtask
endmodule // fbs_host_model

/* tb/fbs_sram_access_test.sv */
// Self-checking bench for the SRAM access block and its posted-write FIFO
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module fbs_sram_access_test;
  localparam logic [16:0] G = 17'h1fffc;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic clock_qualify_n, select_low_first_n, select_high_second, select_low_third_n;
  logic advance_not_load, write_strobe_n, output_drive_n, burst_order;
  logic data_oe, lane_parity_lines_oe, write_buffer_ready;
  logic [16:0] addr;
  logic [3:0] byte_lane_write_n, lane_parity_lines_in, lane_parity_lines_out;
  logic [31:0] data_in, data_out;
  logic [36:0] note;
  logic [2:0] dsel [3] = '{3'h6, 3'h0, 3'h3};
  logic [3:0] wbw [3] = '{4'he, 4'h5, 4'hf};
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 47361;
  fbs_host_model HOST (.sys_clk, .clock_qualify_n, .select_low_first_n, .select_high_second,
    .select_low_third_n, .advance_not_load, .write_strobe_n, .addr, .byte_lane_write_n,
    .output_drive_n, .burst_order, .data_in, .lane_parity_lines_in);
  fbs_sram_access DUT (.sys_clk, .rst_n, .clock_qualify_n, .select_low_first_n, .select_high_second,
    .select_low_third_n, .advance_not_load, .write_strobe_n, .addr, .byte_lane_write_n,
    .output_drive_n, .burst_order, .data_in, .data_out, .data_oe, .lane_parity_lines_in,
    .lane_parity_lines_out, .lane_parity_lines_oe, .write_buffer_ready);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Outputs are settled by the falling edge, so each note is judged there
  always @(negedge sys_clk) if (HOST.notes.size() > 0) begin
    note = HOST.notes.pop_front();
    `CHK(data_oe, note[36])
    `CHK(lane_parity_lines_oe, note[36])
    if (note[36]) `CHK({lane_parity_lines_out, data_out}, note[35:0])
    // Legal traffic drains the posted-write buffer as fast as it fills
    `CHK(write_buffer_ready, 1'b1)
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1;
    `CHK(data_oe, 1'b0)
    `CHK(lane_parity_lines_oe, 1'b0)
    HOST.idle(3);
    $display("reset test done");
    // The group sits at the top of the map, so a carry out of the low bits reads unwritten words
    for (int o = 0; o < 2; o++) begin
      HOST.cfg(o[0], 0);
      for (int i = 0; i < 4; i++) HOST.ld(0, G + 17'(i), 4'h0);
      HOST.idle(4);
      for (int s = 0; s < 4; s++) begin
        HOST.ld(1, G + 17'(s), 4'hf);
        repeat (3) HOST.step(4'h0);
      end
    end
    $display("burst order test done");
    HOST.ld(0, G + 17'h2, 4'h0);
    foreach (wbw[i]) HOST.step(wbw[i]);
    HOST.idle(4);
    HOST.ld(1, G, 4'hf);
    repeat (3) HOST.step(4'hf);
    $display("byte lane test done");
    HOST.ld(1, G + 17'h1, 4'hf);
    HOST.tick(1, 3'b010, 0, 0, '0, 4'h0);
    HOST.step(4'hf);
    HOST.tick(1, 3'b110, 1, 1, '0, 4'hf);
    HOST.step(4'hf);
    $display("stall test done");
    foreach (dsel[k]) begin
      HOST.ld(1, G + 17'(k), 4'hf);
      HOST.tick(0, dsel[k], 0, 1, G, 4'hf);
      HOST.step(4'hf);
    end
    $display("deselect test done");
    HOST.cfg(0, 1);
    HOST.ld(1, G, 4'hf);
    HOST.step(4'hf);
    HOST.cfg(0, 0);
    `CHK(write_buffer_ready, 1'b1)
    $display("drive enable test done");
    // Random lane writes through the posted-write buffer with a stalled data edge, then a wrapping read-back
    repeat (8) begin
      HOST.ld(0, G + 17'($random(seed) & 3), 4'($random(seed)));
      HOST.tick(1, 3'b010, 0, 1, '0, 4'h0);
      HOST.step(4'($random(seed)));
      HOST.idle(2);
      HOST.ld(1, G, 4'hf);
      repeat (4) HOST.step(4'hf);
    end
    `CHK(write_buffer_ready, 1'b1)
    $display("buffer test done");
    // Reset right after a read; the synchronised drive enable needs two edges before reads drive again
    HOST.ld(1, G, 4'hf);
    rst_n = 0;
    HOST.idle(2);
    rst_n = 1;
    `CHK(data_oe, 1'b0)
    `CHK(lane_parity_lines_oe, 1'b0)
    `CHK(write_buffer_ready, 1'b1)
    HOST.idle(2);
    HOST.ld(1, G + 17'h3, 4'hf);
    HOST.step(4'hf);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule // fbs_sram_access_test
